//--- hdl/power_mode_sequencer_regs.svh
// Constants for the power mode sequencer
// Operation
// - Disable pin high puts device to sleep; low makes it active.
// - Divider switches at fixed programmed frequency with 50% duty cycle.
// - Three configurations; Bypass entered at start-up, transmitter connect and transceiver mode.
// - Bypass start-up raises divider output good; host may load at once.
// - Every requested Bypass/Divider change passes through an automatic Disable state; a forced return to Bypass skips it.
// - Divider start pre-charges capacitors to half output with 10mA sources, unloaded.
// - Change refused with alarm while divider output is loaded.
// - After unloaded request, divider starts and signals divider output good.
// - Communication enabled only once rectified voltage exceeds undervoltage lockout.
// - Error packets sent before and after main regulator enable.
// - Main regulator enabled in power transfer once rectified voltage reaches target.
// - Shutdown hold or disable pin forces sleep; no ping answer, no power.
// - Power transfer only after identification, configuration, negotiation and calibration succeed.
// - Received power compared to reference curve; mismatch flags foreign object.
// - Interrupts signalled on open-drain pin; host polls status during transfer.
// - Over-current beyond 0.5s sends end-power-transfer and raises over-current interrupt.
`ifndef POWER_MODE_SEQUENCER_REGS_SVH
`define POWER_MODE_SEQUENCER_REGS_SVH
`define CLK_PERIOD_NS      100_000 / 10_000
`define OC_LIMIT_MS        500
`define OC_LIMIT_CYCLES    ((`OC_LIMIT_MS * 1000 * 1000) / 10)
`define DIV_HALF_PERIOD    8'h0032
`define PRECHARGE_CYCLES   16'h0400
`define ERR_PKT_INTERVAL   16'h2710
`define FOD_MARGIN_RESET   16'h0100
`define DIV_HALF_BITS      8
`define PWR_BITS           16
`endif

//--- hdl/power_mode_sequencer_pkg.sv
// Types for the power mode sequencer
package power_mode_sequencer_pkg;
	typedef enum logic [2:0] {
		PH_SLEEP     = 3'b000,
		PH_SELECT    = 3'b001,
		PH_PING      = 3'b010,
		PH_IDCFG     = 3'b011,
		PH_NEGCAL    = 3'b100,
		PH_TRANSFER  = 3'b101,
		PH_END       = 3'b110
	} phase_e;
	typedef enum logic [1:0] {
		CFG_BYPASS   = 2'b00,
		CFG_DISABLE  = 2'b01,
		CFG_DIVIDER  = 2'b10
	} config_e;
endpackage

//--- hdl/power_mode_sequencer.sv
// Power mode sequencer: sleep, configuration switching, start-up and transfer control
`include "power_mode_sequencer_regs.svh"
module power_mode_sequencer #(
	parameter int OC_LIMIT_CYCLES = `OC_LIMIT_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        device_disable_pin,
	input  wire logic        shutdown_hold_input,
	input  wire logic        vrect_above_uvlo,
	input  wire logic        vrect_at_target,
	input  wire logic        idcfg_ok,
	input  wire logic        negcal_ok,
	input  wire logic        transceiver_mode,
	input  wire logic        divider_request,
	input  wire logic        divider_output_loaded,
	input  wire logic        regulator_overcurrent,
	input  wire logic [15:0] received_power,
	input  wire logic [15:0] reference_power,
	input  wire logic [15:0] fod_margin,
	input  wire logic        ext_5v_select,
	input  wire logic        status_clear,
	output logic             sleep_mode,
	output logic             comm_enable,
	output logic             regulator_enable,
	output logic [1:0]       config_state,
	output logic             precharge_enable,
	output logic             divider_phase_a,
	output logic             divider_phase_b,
	output logic             divider_output_good,
	output logic             config_alarm,
	output logic             foreign_object,
	output logic             overcurrent_flag,
	output logic             error_packet_req,
	output logic             power_report_req,
	output logic             end_transfer_req,
	output logic             external_5v_supply_input_en,
	output logic             open_drain_pin_three_out,
	output logic             open_drain_pin_three_oe
);
	// Pin synchronisers
	logic [1:0] dis_sync_ff, hold_sync_ff, uvlo_sync_ff, tgt_sync_ff, oc_sync_ff;
	logic [1:0] nxt_dis_sync, nxt_hold_sync, nxt_uvlo_sync, nxt_tgt_sync, nxt_oc_sync;
	always_comb begin
		nxt_dis_sync  = {dis_sync_ff[0], device_disable_pin};
		nxt_hold_sync = {hold_sync_ff[0], shutdown_hold_input};
		nxt_uvlo_sync = {uvlo_sync_ff[0], vrect_above_uvlo};
		nxt_tgt_sync  = {tgt_sync_ff[0], vrect_at_target};
		nxt_oc_sync   = {oc_sync_ff[0], regulator_overcurrent};
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			dis_sync_ff  <= 2'h3;
			hold_sync_ff <= 2'h0;
			uvlo_sync_ff <= 2'h0;
			tgt_sync_ff  <= 2'h0;
			oc_sync_ff   <= 2'h0;
		end else begin
			dis_sync_ff  <= nxt_dis_sync;
			hold_sync_ff <= nxt_hold_sync;
			uvlo_sync_ff <= nxt_uvlo_sync;
			tgt_sync_ff  <= nxt_tgt_sync;
			oc_sync_ff   <= nxt_oc_sync;
		end
	end
	logic shut, uvlo_ok, at_tgt, oc_now;
	assign shut    = dis_sync_ff[1] | hold_sync_ff[1];
	assign uvlo_ok = uvlo_sync_ff[1];
	assign at_tgt  = tgt_sync_ff[1];
	assign oc_now  = oc_sync_ff[1];

	// Power transfer phase machine
	power_mode_sequencer_pkg::phase_e phase_ff, nxt_phase;
	logic        reg_en_ff, nxt_reg_en;
	logic [15:0] pkt_cnt_ff, nxt_pkt_cnt;
	logic        err_ff, nxt_err, rpt_ff, nxt_rpt, ept_ff, nxt_ept;
	logic [31:0] oc_cnt_ff, nxt_oc_cnt;
	logic        oc_long;
	assign oc_long = oc_cnt_ff >= 32'(OC_LIMIT_CYCLES);
	always_comb begin
		nxt_phase   = phase_ff;
		nxt_reg_en  = reg_en_ff;
		nxt_pkt_cnt = pkt_cnt_ff;
		nxt_err     = 1'b0;
		nxt_rpt     = 1'b0;
		nxt_ept     = 1'b0;
		nxt_oc_cnt  = oc_now ? ((oc_long) ? oc_cnt_ff : oc_cnt_ff + 32'h0000_0001) : 32'h0000_0000;
		case (phase_ff)
			power_mode_sequencer_pkg::PH_SLEEP: begin
				nxt_reg_en = 1'b0;
				if (!shut)
					nxt_phase = power_mode_sequencer_pkg::PH_SELECT;
			end
			power_mode_sequencer_pkg::PH_SELECT: begin
				if (uvlo_ok)
					nxt_phase = power_mode_sequencer_pkg::PH_PING;
			end
			power_mode_sequencer_pkg::PH_PING: begin
				if (!uvlo_ok)
					nxt_phase = power_mode_sequencer_pkg::PH_SELECT;
				else if (idcfg_ok)
					nxt_phase = power_mode_sequencer_pkg::PH_IDCFG;
			end
			power_mode_sequencer_pkg::PH_IDCFG: begin
				if (!uvlo_ok)
					nxt_phase = power_mode_sequencer_pkg::PH_SELECT;
				else if (negcal_ok)
					nxt_phase = power_mode_sequencer_pkg::PH_NEGCAL;
			end
			power_mode_sequencer_pkg::PH_NEGCAL: begin
				nxt_phase = uvlo_ok ? power_mode_sequencer_pkg::PH_TRANSFER
					: power_mode_sequencer_pkg::PH_SELECT;
			end
			power_mode_sequencer_pkg::PH_TRANSFER: begin
				if (at_tgt)
					nxt_reg_en = 1'b1;
				if (!uvlo_ok) begin
					nxt_phase  = power_mode_sequencer_pkg::PH_SELECT;
					nxt_reg_en = 1'b0;
				end else if (oc_long) begin
					nxt_phase = power_mode_sequencer_pkg::PH_END;
				end
			end
			power_mode_sequencer_pkg::PH_END: begin
				nxt_ept = 1'b1;
				if (!uvlo_ok) begin
					nxt_phase  = power_mode_sequencer_pkg::PH_SELECT;
					nxt_reg_en = 1'b0;
				end
			end
			default: nxt_phase = power_mode_sequencer_pkg::PH_SLEEP;
		endcase
		if (phase_ff == power_mode_sequencer_pkg::PH_PING || phase_ff == power_mode_sequencer_pkg::PH_TRANSFER) begin
			if (pkt_cnt_ff == `ERR_PKT_INTERVAL) begin
				nxt_pkt_cnt = 16'h0000;
				nxt_err     = 1'b1;
				nxt_rpt     = (phase_ff == power_mode_sequencer_pkg::PH_TRANSFER);
			end else begin
				nxt_pkt_cnt = pkt_cnt_ff + 16'h0001;
			end
		end else begin
			nxt_pkt_cnt = 16'h0000;
		end
		if (shut) begin
			nxt_phase  = power_mode_sequencer_pkg::PH_SLEEP;
			nxt_reg_en = 1'b0;
			nxt_err    = 1'b0;
			nxt_rpt    = 1'b0;
			nxt_ept    = 1'b0;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			phase_ff   <= power_mode_sequencer_pkg::PH_SLEEP;
			reg_en_ff  <= 1'b0;
			pkt_cnt_ff <= 16'h0000;
			err_ff     <= 1'b0;
			rpt_ff     <= 1'b0;
			ept_ff     <= 1'b0;
			oc_cnt_ff  <= 32'h0000_0000;
		end else begin
			phase_ff   <= nxt_phase;
			reg_en_ff  <= nxt_reg_en;
			pkt_cnt_ff <= nxt_pkt_cnt;
			err_ff     <= nxt_err;
			rpt_ff     <= nxt_rpt;
			ept_ff     <= nxt_ept;
			oc_cnt_ff  <= nxt_oc_cnt;
		end
	end

	// Configuration machine: Bypass, Disable, Divider
	power_mode_sequencer_pkg::config_e cfg_ff, nxt_cfg;
	logic        target_div_ff, nxt_target_div;
	logic [15:0] pre_cnt_ff, nxt_pre_cnt;
	logic [7:0]  sw_cnt_ff, nxt_sw_cnt;
	logic        sw_ph_ff, nxt_sw_ph;
	logic        good_ff, nxt_good, alarm_ff, nxt_alarm, req_d_ff;
	logic        ph_b_ff, nxt_ph_b;
	logic        req_change, force_bypass;
	assign force_bypass = transceiver_mode || phase_ff == power_mode_sequencer_pkg::PH_SELECT;
	assign req_change   = (divider_request != target_div_ff) && !force_bypass;
	always_comb begin
		nxt_cfg        = cfg_ff;
		nxt_target_div = target_div_ff;
		nxt_pre_cnt    = pre_cnt_ff;
		nxt_good       = good_ff;
		nxt_alarm      = alarm_ff;
		nxt_sw_cnt     = sw_cnt_ff;
		nxt_sw_ph      = sw_ph_ff;
		case (cfg_ff)
			power_mode_sequencer_pkg::CFG_BYPASS,
			power_mode_sequencer_pkg::CFG_DIVIDER: begin
				if (req_change && divider_request != req_d_ff) begin
					if (divider_output_loaded) begin
						nxt_alarm = 1'b1;
					end else begin
						nxt_target_div = divider_request;
						nxt_cfg        = power_mode_sequencer_pkg::CFG_DISABLE;
						nxt_pre_cnt    = 16'h0000;
						nxt_good       = 1'b0;
					end
				end
			end
			power_mode_sequencer_pkg::CFG_DISABLE: begin
				if (pre_cnt_ff == `PRECHARGE_CYCLES) begin
					nxt_cfg  = target_div_ff ? power_mode_sequencer_pkg::CFG_DIVIDER
						: power_mode_sequencer_pkg::CFG_BYPASS;
					nxt_good = 1'b1;
				end else begin
					nxt_pre_cnt = pre_cnt_ff + 16'h0001;
				end
			end
			default: nxt_cfg = power_mode_sequencer_pkg::CFG_BYPASS;
		endcase
		if (cfg_ff == power_mode_sequencer_pkg::CFG_DIVIDER) begin
			if (sw_cnt_ff == `DIV_HALF_PERIOD - 8'h01) begin
				nxt_sw_cnt = 8'h00;
				nxt_sw_ph  = !sw_ph_ff;
			end else begin
				nxt_sw_cnt = sw_cnt_ff + 8'h01;
			end
		end else begin
			nxt_sw_cnt = 8'h00;
			nxt_sw_ph  = 1'b0;
		end
		if (status_clear)
			nxt_alarm = 1'b0;
		if (req_change && divider_request != req_d_ff && divider_output_loaded)
			nxt_alarm = 1'b1;
		if (shut || force_bypass) begin
			nxt_cfg        = power_mode_sequencer_pkg::CFG_BYPASS;
			nxt_target_div = 1'b0;
			nxt_good       = !shut && uvlo_ok;
		end
		// Second phase runs only once the divider has been good for a cycle
		nxt_ph_b = (good_ff && nxt_cfg == power_mode_sequencer_pkg::CFG_DIVIDER) ? !nxt_sw_ph : 1'b0;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_ff        <= power_mode_sequencer_pkg::CFG_BYPASS;
			target_div_ff <= 1'b0;
			pre_cnt_ff    <= 16'h0000;
			sw_cnt_ff     <= 8'h00;
			sw_ph_ff      <= 1'b0;
			good_ff       <= 1'b0;
			alarm_ff      <= 1'b0;
			req_d_ff      <= 1'b0;
			ph_b_ff       <= 1'b0;
		end else begin
			cfg_ff        <= nxt_cfg;
			target_div_ff <= nxt_target_div;
			pre_cnt_ff    <= nxt_pre_cnt;
			sw_cnt_ff     <= nxt_sw_cnt;
			sw_ph_ff      <= nxt_sw_ph;
			good_ff       <= nxt_good;
			alarm_ff      <= nxt_alarm;
			req_d_ff      <= divider_request;
			ph_b_ff       <= nxt_ph_b;
		end
	end

	// Foreign object detection and sticky status
	logic fod_ff, nxt_fod, ocf_ff, nxt_ocf, od_oe_ff, nxt_od_oe, nxt_irq, good_d_ff;
	logic [16:0] diff;
	assign diff = (received_power > reference_power) ? {1'b0, received_power - reference_power}
		: {1'b0, reference_power - received_power};
	always_comb begin
		nxt_fod = fod_ff;
		nxt_ocf = ocf_ff;
		if (status_clear) begin
			nxt_fod = 1'b0;
			nxt_ocf = 1'b0;
		end
		if (phase_ff == power_mode_sequencer_pkg::PH_TRANSFER && diff > {1'b0, fod_margin})
			nxt_fod = 1'b1;
		if (oc_now)
			nxt_ocf = 1'b1;
		nxt_irq   = nxt_fod | nxt_ocf | nxt_alarm | (good_ff & !good_d_ff)
			| (!od_oe_ff & !status_clear);
		nxt_od_oe = !nxt_irq;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			fod_ff    <= 1'b0;
			ocf_ff    <= 1'b0;
			od_oe_ff  <= 1'b1;
			good_d_ff <= 1'b0;
		end else begin
			fod_ff    <= nxt_fod;
			ocf_ff    <= nxt_ocf;
			od_oe_ff  <= nxt_od_oe;
			good_d_ff <= good_ff;
		end
	end

	// Registered outputs
	logic out_sleep_ff, out_comm_ff, out_pre_ff, out_5v_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			out_sleep_ff <= 1'b1;
			out_comm_ff  <= 1'b0;
			out_pre_ff   <= 1'b0;
			out_5v_ff    <= 1'b0;
		end else begin
			out_sleep_ff <= phase_ff == power_mode_sequencer_pkg::PH_SLEEP;
			out_comm_ff  <= phase_ff != power_mode_sequencer_pkg::PH_SLEEP
				&& phase_ff != power_mode_sequencer_pkg::PH_SELECT;
			out_pre_ff   <= cfg_ff == power_mode_sequencer_pkg::CFG_DISABLE;
			out_5v_ff    <= ext_5v_select && phase_ff != power_mode_sequencer_pkg::PH_SLEEP;
		end
	end
	assign sleep_mode                  = out_sleep_ff;
	assign comm_enable                 = out_comm_ff;
	assign regulator_enable            = reg_en_ff;
	assign config_state                = cfg_ff;
	assign precharge_enable            = out_pre_ff;
	assign divider_phase_a             = sw_ph_ff;
	assign divider_phase_b             = ph_b_ff;
	assign divider_output_good         = good_ff;
	assign config_alarm                = alarm_ff;
	assign foreign_object              = fod_ff;
	assign overcurrent_flag            = ocf_ff;
	assign error_packet_req            = err_ff;
	assign power_report_req            = rpt_ff;
	assign end_transfer_req            = ept_ff;
	assign external_5v_supply_input_en = out_5v_ff;
	assign open_drain_pin_three_out    = 1'b0;
	assign open_drain_pin_three_oe     = od_oe_ff;
endmodule

//--- verif/power_mode_sequencer_asserts.sv
// Port-level checker for the power mode sequencer
module power_mode_sequencer_asserts #(
	parameter int OC_LIMIT_CYCLES = 100
) (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       device_disable_pin,
	input wire logic       shutdown_hold_input,
	input wire logic       vrect_above_uvlo,
	input wire logic       transceiver_mode,
	input wire logic       divider_request,
	input wire logic       divider_output_loaded,
	input wire logic       status_clear,
	input wire logic       sleep_mode,
	input wire logic       comm_enable,
	input wire logic       regulator_enable,
	input wire logic [1:0] config_state,
	input wire logic       precharge_enable,
	input wire logic       divider_phase_a,
	input wire logic       divider_phase_b,
	input wire logic       divider_output_good,
	input wire logic       config_alarm,
	input wire logic       overcurrent_flag,
	input wire logic       error_packet_req,
	input wire logic       end_transfer_req,
	input wire logic       open_drain_pin_three_out,
	input wire logic       open_drain_pin_three_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_req;
		$changed(divider_request) && comm_enable && !transceiver_mode && config_state != 2'h1;
	endsequence
	property p_sleep; (device_disable_pin || shutdown_hold_input)[*5] |-> sleep_mode; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	property p_quiet; sleep_mode[*2] |-> !comm_enable && !regulator_enable && !error_packet_req; endproperty
	a_quiet: assert property (p_quiet) else $error("activity while asleep");
	property p_uvlo; (!vrect_above_uvlo)[*6] |-> !comm_enable; endproperty
	a_uvlo: assert property (p_uvlo) else $error("comm below lockout");
	property p_reg; regulator_enable |-> comm_enable; endproperty
	a_reg: assert property (p_reg) else $error("regulator outside transfer");
	property p_refuse; s_req ##0 divider_output_loaded |=> config_alarm && $stable(config_state); endproperty
	a_refuse: assert property (p_refuse) else $error("loaded change not refused");
	property p_disable; s_req ##0 !divider_output_loaded |=> config_state == 2'h1; endproperty
	a_disable: assert property (p_disable) else $error("change skipped disable");
	property p_div;
		$changed(config_state) && config_state == 2'h2 |-> $past(config_state) == 2'h1 && divider_output_good;
	endproperty
	a_div: assert property (p_div) else $error("divider entry wrong");
	property p_pre; precharge_enable |-> $past(config_state) == 2'h1; endproperty
	a_pre: assert property (p_pre) else $error("precharge outside disable");
	property p_split; (config_state == 2'h2)[*3] |-> divider_phase_a != divider_phase_b; endproperty
	a_split: assert property (p_split) else $error("phases not complementary");
	property p_hold; $rose(divider_phase_a) |-> (divider_phase_a || config_state != 2'h2)[*8]; endproperty
	a_hold: assert property (p_hold) else $error("phase high too short");
	property p_tx; transceiver_mode && config_state == 2'h0 |=> config_state == 2'h0; endproperty
	a_tx: assert property (p_tx) else $error("bypass left in transceiver mode");
	property p_irq; config_alarm[*2] |-> !open_drain_pin_three_oe && !open_drain_pin_three_out; endproperty
	a_irq: assert property (p_irq) else $error("interrupt not driven");
	property p_oc; overcurrent_flag && !status_clear |=> overcurrent_flag; endproperty
	a_oc: assert property (p_oc) else $error("overcurrent flag lost");
	c_good: cover property ($rose(divider_output_good));
	c_alarm: cover property ($rose(config_alarm));
	c_ept: cover property ($rose(end_transfer_req));
endmodule

//--- verif/pms_host_model.sv
// Host processor model: orders load removal and configuration requests
module pms_host_model (
	input  wire logic clk,
	input  wire logic want_div,
	input  wire logic rude,
	input  wire logic load_want,
	output logic      divider_request,
	output logic      divider_output_loaded
);
	timeunit 1ns;
	timeprecision 1ps;
	logic want_q = 1'b0, rude_q = 1'b0, load_q = 1'b0;
	initial begin
		divider_request = 1'b0;
		divider_output_loaded = 1'b0;
	end
	// Commands latched on the rising edge so the falling-edge update never races the bench
	always @(posedge clk) begin
		want_q <= want_div;
		rude_q <= rude;
		load_q <= load_want;
	end
	always @(negedge clk) begin
		if (want_q !== divider_request && divider_output_loaded && !rude_q) begin
			divider_output_loaded <= 1'b0;
		end else if (want_q !== divider_request) begin
			divider_request <= want_q;
		end else begin
			divider_output_loaded <= load_q;
		end
	end
endmodule

//--- verif/test_power_mode_sequencer.sv
// Self-checking bench for the power mode sequencer
module test_power_mode_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OC_LIM = 100;
	logic        clk = 0, reset = 1, device_disable_pin = 0, shutdown_hold_input = 0, vrect_above_uvlo = 0;
	logic        vrect_at_target = 0, idcfg_ok = 0, negcal_ok = 0, transceiver_mode = 0, regulator_overcurrent = 0;
	logic        ext_5v_select = 0, status_clear = 0, want_div = 0, rude = 0, load_want = 0;
	logic        divider_request, divider_output_loaded, sleep_mode, comm_enable, regulator_enable;
	logic        precharge_enable, divider_phase_a, divider_phase_b, divider_output_good, config_alarm;
	logic        foreign_object, overcurrent_flag, error_packet_req, power_report_req, end_transfer_req;
	logic        external_5v_supply_input_en, open_drain_pin_three_out, open_drain_pin_three_oe;
	logic [15:0] received_power = 0, reference_power = 0, fod_margin = 16'h0100;
	logic [1:0]  config_state;
	logic [31:0] seed = 32'h0000_1b50;
	int          n_fail = 0, checks_done = 0, exp_cfg = 0, i, k;
	always #5 clk = ~clk;
	power_mode_sequencer #(.OC_LIMIT_CYCLES(OC_LIM)) i_dut (
		.clk(clk), .reset(reset), .device_disable_pin(device_disable_pin),
		.shutdown_hold_input(shutdown_hold_input), .vrect_above_uvlo(vrect_above_uvlo),
		.vrect_at_target(vrect_at_target), .idcfg_ok(idcfg_ok), .negcal_ok(negcal_ok),
		.transceiver_mode(transceiver_mode), .divider_request(divider_request),
		.divider_output_loaded(divider_output_loaded), .regulator_overcurrent(regulator_overcurrent),
		.received_power(received_power), .reference_power(reference_power), .fod_margin(fod_margin),
		.ext_5v_select(ext_5v_select), .status_clear(status_clear), .sleep_mode(sleep_mode),
		.comm_enable(comm_enable), .regulator_enable(regulator_enable), .config_state(config_state),
		.precharge_enable(precharge_enable), .divider_phase_a(divider_phase_a),
		.divider_phase_b(divider_phase_b), .divider_output_good(divider_output_good),
		.config_alarm(config_alarm), .foreign_object(foreign_object), .overcurrent_flag(overcurrent_flag),
		.error_packet_req(error_packet_req), .power_report_req(power_report_req),
		.end_transfer_req(end_transfer_req), .external_5v_supply_input_en(external_5v_supply_input_en),
		.open_drain_pin_three_out(open_drain_pin_three_out), .open_drain_pin_three_oe(open_drain_pin_three_oe)
	);
	pms_host_model i_host (.clk, .want_div, .rude, .load_want, .divider_request, .divider_output_loaded);
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		for (int n = 0; n < lim && s !== 1'b1; n++) @(negedge clk);
	endtask
	task automatic pulse_clear();
		status_clear = 1;
		@(negedge clk);
		status_clear = 0;
		@(negedge clk);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#800000;
		n_fail++;
		stop_test();
	end
	initial begin
		repeat (20) @(negedge clk);
		reset = 0;
		vrect_above_uvlo = 1;
		for (i = 0; i < 2; i++) begin
			repeat (6) @(negedge clk);
			chk("awake", 0, sleep_mode);
			{shutdown_hold_input, device_disable_pin} = 2'h1 << i;
			repeat (6) @(negedge clk);
			chk("asleep", 1, sleep_mode);
			chk("comm_asleep", 0, comm_enable);
			{shutdown_hold_input, device_disable_pin} = 2'h0;
		end
		wait_hi(comm_enable, 200);
		chk("comm", 1, comm_enable);
		idcfg_ok = 1;
		negcal_ok = 1;
		repeat (10) @(negedge clk);
		chk("reg_early", 0, regulator_enable);
		vrect_at_target = 1;
		wait_hi(regulator_enable, 50);
		chk("reg", 1, regulator_enable);
		chk("good_boot", 1, divider_output_good);
		wait_hi(error_packet_req, 12000);
		chk("err_pkt", 1, error_packet_req);
		ext_5v_select = 1;
		repeat (3) @(negedge clk);
		chk("ext5v", 1, external_5v_supply_input_en);
		load_want = 1;
		rude = 1;
		repeat (3) @(negedge clk);
		want_div = 1;
		repeat (4) @(negedge clk);
		chk("cfg_refused", 16'(exp_cfg), config_state);
		chk("alarm", 1, config_alarm);
		chk("irq_oe", 0, open_drain_pin_three_oe);
		chk("irq_out", 0, open_drain_pin_three_out);
		want_div = 0;
		repeat (3) @(negedge clk);
		pulse_clear();
		chk("alarm_clr", 0, config_alarm);
		rude = 0;
		load_want = 0;
		want_div = 1;
		for (i = 0; i < 10 && config_state !== 2'h1; i++) @(negedge clk);
		exp_cfg = 1;
		chk("cfg_disable", 16'(exp_cfg), config_state);
		@(negedge clk);
		chk("precharge", 1, precharge_enable);
		for (i = 0; i < 2000 && config_state !== 2'h2; i++) @(negedge clk);
		exp_cfg = 2;
		chk("precharge_len", 16'h0400, 16'(i));
		chk("cfg_div", 16'(exp_cfg), config_state);
		chk("good_div", 1, divider_output_good);
		wait_hi(divider_phase_a, 200);
		for (i = 0; i < 200 && divider_phase_a !== 1'b0; i++) @(negedge clk);
		chk("half_period", 16'h0032, 16'(i));
		chk("phase_b", 1, divider_phase_b);
		want_div = 0;
		for (i = 0; i < 3000 && config_state !== 2'h0; i++) @(negedge clk);
		exp_cfg = 0;
		chk("cfg_back", 16'(exp_cfg), config_state);
		for (k = 0; k < 2; k++) begin
			received_power = rnd() & 16'h3fff;
			reference_power = received_power + (k[0] ? 16'h0010 : 16'h0400);
			pulse_clear();
			wait_hi(power_report_req, 12000);
			chk("report", 1, power_report_req);
			repeat (4) @(negedge clk);
			chk("fod", 16'(int'(reference_power) - int'(received_power) > int'(fod_margin)), foreign_object);
		end
		regulator_overcurrent = 1;
		repeat (OC_LIM / 2) @(negedge clk);
		chk("ept_early", 0, end_transfer_req);
		wait_hi(end_transfer_req, OC_LIM + 20);
		chk("ept", 1, end_transfer_req);
		chk("oc_flag", 1, overcurrent_flag);
		regulator_overcurrent = 0;
		transceiver_mode = 1;
		repeat (3) @(negedge clk);
		want_div = 1;
		repeat (6) @(negedge clk);
		chk("cfg_tx", 16'(exp_cfg), config_state);
		vrect_above_uvlo = 0;
		repeat (8) @(negedge clk);
		chk("comm_uvlo", 0, comm_enable);
		chk("reg_uvlo", 0, regulator_enable);
		stop_test();
	end
endmodule
bind power_mode_sequencer power_mode_sequencer_asserts #(.OC_LIMIT_CYCLES(OC_LIMIT_CYCLES)) i_chk (
	.clk(clk), .reset(reset), .device_disable_pin(device_disable_pin), .shutdown_hold_input(shutdown_hold_input),
	.vrect_above_uvlo(vrect_above_uvlo), .transceiver_mode(transceiver_mode), .divider_request(divider_request),
	.divider_output_loaded(divider_output_loaded), .status_clear(status_clear), .sleep_mode(sleep_mode),
	.comm_enable(comm_enable), .regulator_enable(regulator_enable), .config_state(config_state),
	.precharge_enable(precharge_enable), .divider_phase_a(divider_phase_a), .divider_phase_b(divider_phase_b),
	.divider_output_good(divider_output_good), .config_alarm(config_alarm), .overcurrent_flag(overcurrent_flag),
	.error_packet_req(error_packet_req), .end_transfer_req(end_transfer_req),
	.open_drain_pin_three_out(open_drain_pin_three_out), .open_drain_pin_three_oe(open_drain_pin_three_oe)
);
